// *** src/long_term_accumulator_access.sv ***
/*
  Long-term store control: front-end accumulation of short-term results, backend
  read port for the downstream filter card, window arbiter and AHB-Lite registers.
  Assumes the short-term cards and the filter card run on hclk; the storage array
  is modelled in-block, refresh is signalled by a strobe to the memory timing logic.
*/
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module long_term_accumulator_access
  import lta_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int WIN_CLKS = WINDOW_CLKS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // short-term results in
  input wire logic short_term_transfer_strobe,
  input wire logic [7:0] in_baseline,
  input wire logic [2:0] in_array,
  input wire logic [7:0] in_point,
  input wire logic [14:0] in_real,
  input wire logic [14:0] in_imag,
  input wire logic [5:0] in_exp,
  output logic front_ready,
  // backend read port
  input wire logic result_request_strobe,
  input wire logic [19:0] result_addr,
  input wire logic force_bank,
  output logic output_word_strobe,
  output logic [31:0] output_data,
  // floating point mode word and refresh
  output logic fp_mode_strobe,
  output logic [31:0] fp_mode_word,
  output logic refresh_strobe
);
  // storage and lookup tables
  logic [63:0] store [0:(1 << ADDR_W) - 1];
  logic [3:0] map_ram [0:255];
  logic [11:0] fe_xlat [0:32767];
  logic [10:0] be_xlat [0:32767];

  // registers
  logic [7:0] accum_clear;
  logic [7:0] acc_bank;
  logic [31:0] mode_word;
  logic [16:0] tbl_addr;
  logic [19:0] mem_addr;
  logic [31:0] mem_lo;
  logic [31:0] mem_hi;
  logic cpu_write;
  logic cpu_pending;
  logic mode_pending;
  logic wr_act;
  logic rd_act;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] rd_mux;
  logic [31:0] tbl_rd;

  // window timing and arbitration
  logic [7:0] win_cnt;
  logic [2:0] win_idx;
  logic refreshed;
  grant_t grant;
  grant_t next_grant;
  logic filt_pending;
  logic [19:0] req_addr;
  logic req_force;
  logic [63:0] be_rd;
  logic be_valid;

  // front end
  fe_state_t fe_state;
  fe_state_t next_fe_state;
  logic [19:0] fe_addr;
  logic [31:0] fe_re;
  logic [31:0] fe_im;
  logic fe_clear;
  logic [63:0] fe_old;

  // bus address phase decode
  wire addr_phase = hsel && hready && htrans[1];
  wire [7:0] ap_ofs = haddr[7:0];

  // table readback; reads of table words never loaded give X, the arrays have no reset
  wire [3:0] tbl_map_q = map_ram[tbl_addr[7:0]];
  wire [11:0] tbl_fe_q = fe_xlat[tbl_addr[14:0]];
  wire [10:0] tbl_be_q = be_xlat[tbl_addr[14:0]];
  assign tbl_rd = (tbl_addr[16:15] == TBL_MAP) ? {28'h000_0000, tbl_map_q} :
                  (tbl_addr[16:15] == TBL_FE_XLAT) ? {20'h0_0000, tbl_fe_q} :
                  (tbl_addr[16:15] == TBL_BE_XLAT) ? {21'h00_0000, tbl_be_q} : 32'h0000_0000;

  // read mux, unmapped offsets read zero
  assign rd_mux = (rd_addr == OFS_ACCUM_CLEAR) ? {24'h00_0000, accum_clear} :
                  (rd_addr == OFS_ACC_BANK) ? {24'h00_0000, acc_bank} :
                  (rd_addr == OFS_MODE_WORD) ? mode_word :
                  (rd_addr == OFS_TBL_ADDR) ? {15'h0000, tbl_addr} :
                  (rd_addr == OFS_TBL_DATA) ? tbl_rd :
                  (rd_addr == OFS_MEM_ADDR) ? {12'h000, mem_addr} :
                  (rd_addr == OFS_MEM_LO) ? mem_lo :
                  (rd_addr == OFS_MEM_HI) ? mem_hi :
                  (rd_addr == OFS_MEM_CMD) ?
                    {24'h00_0000, win_idx, refreshed, filt_pending, mode_pending,
                     cpu_write, cpu_pending} : 32'h0000_0000;

  // bus phases: writes take no wait, reads one wait so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_act <= 1'b0;
      rd_act <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_act <= addr_phase && hwrite;
      rd_act <= addr_phase && !hwrite;
      if (addr_phase) wr_addr <= ap_ofs;
      if (addr_phase && !hwrite) rd_addr <= ap_ofs;
      hreadyout <= !(addr_phase && !hwrite);
      if (rd_act) hrdata <= rd_mux;
    end
  end

  wire wr_strobe = wr_act;
  wire [3:0] wr_map = hwdata[3:0];

  // software registers; hardware clear of a pending flag loses to a new request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accum_clear <= 8'h00;
      acc_bank <= 8'h00;
      mode_word <= 32'h0000_0000;
      tbl_addr <= 17'h0_0000;
      mem_addr <= 20'h0_0000;
      mem_lo <= 32'h0000_0000;
      mem_hi <= 32'h0000_0000;
      cpu_write <= 1'b0;
      cpu_pending <= 1'b0;
      mode_pending <= 1'b0;
    end else begin
      if (win_cnt == SLOT_GRANT && next_grant == GR_CPU) cpu_pending <= 1'b0;
      if (win_cnt == SLOT_GRANT && next_grant == GR_MODE) mode_pending <= 1'b0;
      if (win_cnt == SLOT_REAL && grant == GR_CPU && !cpu_write) begin
        mem_hi <= be_rd[63:32];
        mem_lo <= be_rd[31:0];
      end
      if (wr_strobe) begin
        unique case (wr_addr)
          OFS_ACCUM_CLEAR: accum_clear <= hwdata[7:0];
          OFS_ACC_BANK: acc_bank <= hwdata[7:0];
          OFS_MODE_WORD: begin
            mode_word <= hwdata;
            mode_pending <= 1'b1;
          end
          OFS_TBL_ADDR: tbl_addr <= hwdata[16:0];
          OFS_MEM_ADDR: mem_addr <= hwdata[19:0];
          OFS_MEM_LO: mem_lo <= hwdata;
          OFS_MEM_HI: mem_hi <= hwdata;
          OFS_MEM_CMD: begin
            cpu_write <= hwdata[CMD_WRITE_BIT];
            cpu_pending <= hwdata[0];
          end
          default: ;
        endcase
      end
    end
  end

  // table loads through the table data register
  wire tbl_wr = wr_strobe && wr_addr == OFS_TBL_DATA;
  always_ff @(posedge hclk) begin
    if (tbl_wr && tbl_addr[16:15] == TBL_MAP) map_ram[tbl_addr[7:0]] <= wr_map;
    if (tbl_wr && tbl_addr[16:15] == TBL_FE_XLAT) fe_xlat[tbl_addr[14:0]] <= hwdata[11:0];
    if (tbl_wr && tbl_addr[16:15] == TBL_BE_XLAT) be_xlat[tbl_addr[14:0]] <= hwdata[10:0];
  end

  // window counter: eight windows per FFT cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_cnt <= 8'h00;
      win_idx <= 3'h0;
    end else if (win_cnt == 8'(WIN_CLKS - 1)) begin
      win_cnt <= 8'h00;
      win_idx <= win_idx + 3'h1;
    end else begin
      win_cnt <= win_cnt + 8'h01;
    end
  end

  // priority; refresh fills every window nobody else wants
  // last cycle's flag is stale at the first window, so it is masked there
  wire fft_start = win_cnt == SLOT_GRANT && win_idx == 3'h0;
  wire refreshed_now = refreshed && !fft_start;
  wire refresh_due = win_idx == LAST_WINDOW && !refreshed_now;
  assign next_grant = mode_pending ? GR_MODE :
                      refresh_due ? GR_REFRESH :
                      filt_pending ? GR_FILTER :
                      !refreshed_now ? GR_REFRESH :
                      cpu_pending ? GR_CPU : GR_REFRESH;

  // grant, refresh bookkeeping and filter request latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant <= GR_NONE;
      refreshed <= 1'b0;
      filt_pending <= 1'b0;
      req_addr <= 20'h0_0000;
      req_force <= 1'b0;
      refresh_strobe <= 1'b0;
    end else begin
      if (win_cnt == SLOT_GRANT) grant <= next_grant;
      if (fft_start) refreshed <= 1'b0;
      if (win_cnt == SLOT_GRANT && next_grant == GR_REFRESH) refreshed <= 1'b1;
      refresh_strobe <= win_cnt == SLOT_GRANT && next_grant == GR_REFRESH;
      // held until the imaginary word so the address stays put through the window
      if (win_cnt == SLOT_IMAG && grant == GR_FILTER) filt_pending <= 1'b0;
      // a request while one waits is ignored, also in the cycle the clear happens
      if (result_request_strobe && !filt_pending) begin
        filt_pending <= 1'b1;
        req_addr <= result_addr;
        req_force <= force_bank;
      end
    end
  end

  // backend address: bank, baseline, translated result
  wire [3:0] be_code = map_ram[req_addr[18:11]];
  wire [10:0] be_result = be_xlat[{be_code, req_addr[10:0]}];
  wire be_bank = req_force ? req_addr[19] : !acc_bank[be_code[2:0]];
  wire [19:0] be_addr = (grant == GR_CPU) ? mem_addr : {be_bank, req_addr[18:11], be_result};
  wire be_mem = win_cnt == SLOT_MEM && (grant == GR_FILTER || grant == GR_CPU);
  assign be_valid = be_code[MAP_VALIDITY_BIT] || req_addr[18:11] >= TAPE_BASELINE;

  // output strobes: real then imaginary, validity copied into both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_word_strobe <= 1'b0;
      output_data <= 32'h0000_0000;
      fp_mode_strobe <= 1'b0;
      fp_mode_word <= 32'h0000_0000;
    end else begin
      output_word_strobe <= grant == GR_FILTER &&
                            (win_cnt == SLOT_REAL || win_cnt == SLOT_IMAG);
      if (grant == GR_FILTER && win_cnt == SLOT_REAL) output_data <= be_rd[63:32];
      if (grant == GR_FILTER && win_cnt == SLOT_IMAG)
        output_data <= be_valid ? be_rd[63:32] : be_rd[31:0];
      fp_mode_strobe <= grant == GR_MODE && win_cnt == SLOT_MEM;
      if (grant == GR_MODE && win_cnt == SLOT_MEM) fp_mode_word <= mode_word;
    end
  end

  // front-end mapping of an incoming result
  wire [3:0] in_code = map_ram[in_baseline];
  wire in_is_val = in_code[MAP_VALIDITY_BIT] || in_baseline == TAPE_BASELINE ||
                   in_baseline == PULSAR_BASELINE_A || in_baseline == PULSAR_BASELINE_B;
  wire [10:0] in_index = in_is_val ? {in_point, in_array} : {in_array, in_point};
  wire [3:0] in_map = {in_is_val, in_code[2:0]};
  wire [11:0] in_xlat = fe_xlat[{in_map, in_index}];
  wire in_drop = in_baseline == TAPE_BASELINE && in_point >= TAPE_STROBES_USED;
  wire in_take = short_term_transfer_strobe && fe_state == FE_IDLE;
  wire in_clear = accum_clear[in_code[2:0]] && !in_xlat[XLAT_INHIBIT_BIT];

  // accumulation: clear adds zero, otherwise old plus new
  wire [63:0] fe_sum = fe_clear ? {fe_re, fe_im} :
                       {fp_add(fe_old[63:32], fe_re), fp_add(fe_old[31:0], fe_im)};

  // front-end sequence; the backend slot holds it off the storage
  always_comb begin
    next_fe_state = fe_state;
    unique case (fe_state)
      FE_IDLE: if (in_take && !in_drop) next_fe_state = FE_READ;
      FE_READ: if (!be_mem) next_fe_state = FE_WRITE;
      FE_WRITE: if (!be_mem) next_fe_state = FE_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fe_state <= FE_IDLE;
      front_ready <= 1'b1;
      fe_addr <= 20'h0_0000;
      fe_re <= 32'h0000_0000;
      fe_im <= 32'h0000_0000;
      fe_clear <= 1'b0;
    end else begin
      fe_state <= next_fe_state;
      front_ready <= next_fe_state == FE_IDLE;
      if (in_take) begin
        fe_addr <= {acc_bank[in_code[2:0]], in_baseline, in_xlat[10:0]};
        fe_re <= to_ieee(in_real, in_exp);
        fe_im <= to_ieee(in_imag, in_exp);
        fe_clear <= in_clear;
      end
    end
  end

  // storage port: backend slot first, then the front end
  always_ff @(posedge hclk) begin
    if (be_mem) begin
      be_rd <= store[be_addr[ADDR_W-1:0]];
      if (grant == GR_CPU && cpu_write) store[be_addr[ADDR_W-1:0]] <= {mem_hi, mem_lo};
    end else if (fe_state == FE_READ) begin
      fe_old <= store[fe_addr[ADDR_W-1:0]];
    end else if (fe_state == FE_WRITE) begin
      store[fe_addr[ADDR_W-1:0]] <= fe_sum;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_window_wrap: assert property (
    win_cnt == 8'(WIN_CLKS - 1) |=> win_cnt == 8'h00 && win_idx == $past(win_idx) + 3'h1)
    else $error("window counter did not wrap");
  a_mode_first: assert property (
    win_cnt == SLOT_GRANT && mode_pending |=> grant == GR_MODE ##1 fp_mode_strobe)
    else $error("mode word not given the window");
  a_last_refresh: assert property (
    win_cnt == SLOT_GRANT && refresh_due && !mode_pending |=> grant == GR_REFRESH)
    else $error("last window did not refresh");
  a_refresh_each_fft: assert property (
    win_idx == LAST_WINDOW && win_cnt == 8'(WIN_CLKS - 1) && grant != GR_MODE |-> refreshed)
    else $error("fft cycle ended without refresh");
  a_filter_order: assert property (
    win_cnt == SLOT_GRANT && filt_pending && !mode_pending && !refresh_due
    |=> grant == GR_FILTER ##2 output_word_strobe)
    else $error("filter not served first");
  a_cpu_spare: assert property (
    win_cnt == SLOT_GRANT && next_grant == GR_CPU |-> !filt_pending && refreshed && !fft_start)
    else $error("cpu took a busy window");
  a_two_words: assert property (
    output_word_strobe && !$past(output_word_strobe)
    |=> output_word_strobe ##1 !output_word_strobe)
    else $error("read did not give exactly two words");
  a_validity_copy: assert property (
    $rose(output_word_strobe) && be_valid |=> output_data == $past(output_data))
    else $error("validity words differ");
  a_tape_drop: assert property (
    in_take && in_drop |=> fe_state == FE_IDLE && front_ready)
    else $error("unused tape strobe accumulated");
  a_read_then_write: assert property (
    fe_state == FE_READ && !be_mem |=> fe_state == FE_WRITE)
    else $error("accumulate skipped write back");

  c_filter_read: cover property (grant == GR_FILTER ##2 output_word_strobe [*2]);
  c_cpu_window: cover property (grant == GR_CPU && win_cnt == SLOT_MEM);
  c_tape_validity: cover property (in_take && in_baseline == TAPE_BASELINE && !in_drop);
  c_mode_write: cover property (fp_mode_strobe);
endmodule

// *** src/lta_pkg.sv ***
/*
  Shared constants, types and arithmetic for the long-term accumulator access block.
  Assumes a single 100 MHz clock and a 32-bit AHB-Lite register bus.
*/
package lta_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WINDOW_TIME_NS = 2000;
  localparam int WINDOW_CLKS = WINDOW_TIME_NS / CLK_PERIOD_NS;
  localparam int WINDOWS_PER_FFT = 8;
  // slots inside a backend window
  localparam logic [7:0] SLOT_GRANT = 8'h00;
  localparam logic [7:0] SLOT_MEM = 8'h01;
  localparam logic [7:0] SLOT_REAL = 8'h02;
  localparam logic [7:0] SLOT_IMAG = 8'h03;
  localparam logic [2:0] LAST_WINDOW = 3'h7;
  // register byte offsets
  localparam logic [7:0] OFS_ACCUM_CLEAR = 8'h00;
  localparam logic [7:0] OFS_ACC_BANK = 8'h04;
  localparam logic [7:0] OFS_MODE_WORD = 8'h08;
  localparam logic [7:0] OFS_TBL_ADDR = 8'h0C;
  localparam logic [7:0] OFS_TBL_DATA = 8'h10;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
  localparam logic [7:0] OFS_MEM_LO = 8'h18;
  localparam logic [7:0] OFS_MEM_HI = 8'h1C;
  localparam logic [7:0] OFS_MEM_CMD = 8'h20;
  // table select in the table address register
  localparam logic [1:0] TBL_MAP = 2'h0;
  localparam logic [1:0] TBL_FE_XLAT = 2'h1;
  localparam logic [1:0] TBL_BE_XLAT = 2'h2;
  // field positions
  localparam int CMD_WRITE_BIT = 1;
  localparam int XLAT_INHIBIT_BIT = 11;
  localparam int MAP_VALIDITY_BIT = 3;
  // artificial baselines for validities, and the count of tape strobes used
  localparam logic [7:0] TAPE_BASELINE = 8'hD2;
  localparam logic [7:0] PULSAR_BASELINE_A = 8'hD3;
  localparam logic [7:0] PULSAR_BASELINE_B = 8'hD4;
  localparam logic [7:0] TAPE_STROBES_USED = 8'hD2;
  // floating point
  localparam logic [7:0] IEEE_BIAS = 8'h7F;

  typedef enum logic [1:0] {FE_IDLE, FE_READ, FE_WRITE} fe_state_t;
  typedef enum logic [2:0] {GR_NONE, GR_MODE, GR_REFRESH, GR_FILTER, GR_CPU} grant_t;

  // signed 15-bit mantissa times 2^exp, to single precision
  function automatic logic [31:0] to_ieee(input logic [14:0] m, input logic [5:0] e);
    logic [14:0] mag;
    logic [37:0] t;
    logic [31:0] r;
    int p;
    mag = m[14] ? 15'(-m) : m;
    p = 0;
    r = 32'h0000_0000;
    for (int i = 0; i < 15; i++) begin
      if (mag[i]) p = i;
    end
    t = {mag, 23'h00_0000} >> p;
    if (mag != 15'h0000) begin
      r[31] = m[14];
      r[30:23] = 8'(IEEE_BIAS + e + 8'(p));
      r[22:0] = t[22:0];
    end
    return r;
  endfunction

  // single precision add, truncating; zero exponent counts as zero
  function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] x;
    logic [31:0] y;
    logic [7:0] d;
    logic [7:0] ex;
    logic [24:0] mx;
    logic [24:0] my;
    logic [24:0] s;
    int p;
    x = (a[30:0] < b[30:0]) ? b : a;
    y = (a[30:0] < b[30:0]) ? a : b;
    d = x[30:23] - y[30:23];
    ex = x[30:23];
    mx = {2'b01, x[22:0]};
    my = (d > 8'h18) ? 25'h000_0000 : ({2'b01, y[22:0]} >> d);
    s = (x[31] == y[31]) ? mx + my : mx - my;
    p = 0;
    if (y[30:23] == 8'h00) return x;
    if (s == 25'h000_0000) return 32'h0000_0000;
    if (s[24]) begin
      s = s >> 1;
      ex = ex + 8'h01;
    end else begin
      for (int i = 0; i < 24; i++) begin
        if (s[i]) p = i;
      end
      s = s << (23 - p);
      ex = ex - 8'(23 - p);
    end
    return {x[31], ex, s[22:0]};
  endfunction
endpackage

// *** testbench/filter_card_model.sv ***
/*
  Downstream filter card model: issues result requests, collects output words.
  Assumes everything runs on hclk and at most one request is outstanding.
*/
`timescale 1ns/1ps
module filter_card_model (
  // clock
  input wire logic hclk,
  // words from the block
  input wire logic output_word_strobe,
  input wire logic [31:0] output_data,
  // request to the block
  output logic result_request_strobe,
  output logic [19:0] result_addr,
  output logic force_bank,
  // captured fifo words
  output logic [31:0] real_word,
  output logic [31:0] imag_word,
  output int n_words
);
  initial begin
    result_request_strobe = 1'b0;
    result_addr = 20'h0_0000;
    force_bank = 1'b0;
    n_words = 0;
  end
  // fifo write side: even count takes the real word, odd the imag
  always @(posedge hclk) begin
    if (output_word_strobe === 1'b1) begin
      if (n_words % 2 == 0) real_word <= output_data;
      else imag_word <= output_data;
      n_words <= n_words + 1;
    end
  end
  // one-cycle strobe; address scrambled after, the reader no longer holds it
  task automatic request(input logic [19:0] a, input logic fb);
    @(posedge hclk);
    result_request_strobe <= 1'b1;
    result_addr <= a;
    force_bank <= fb;
    @(posedge hclk);
    result_request_strobe <= 1'b0;
    result_addr <= ~a;
    force_bank <= ~fb;
  endtask
endmodule

// *** testbench/long_term_accumulator_access_tb.sv ***
/*
  Self-checking bench: registers over AHB-Lite, front-end accumulation, backend reads.
  Assumes the filter card model on the backend port and a short access window.
*/
`timescale 1ns/1ps
module long_term_accumulator_access_tb;
  import lta_pkg::*;
  localparam int WIN = 8;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, front_ready, busy_seen;
  logic short_term_transfer_strobe, result_request_strobe, force_bank;
  logic output_word_strobe, fp_mode_strobe, refresh_strobe;
  logic [1:0] htrans;
  logic [2:0] hsize, in_array;
  logic [5:0] in_exp;
  logic [7:0] in_baseline, in_point;
  logic [14:0] in_real, in_imag;
  logic [19:0] result_addr;
  logic [31:0] haddr, hwdata, hrdata, output_data, fp_mode_word, real_word, imag_word, rd;
  int n_words, n_fail, n_compared;

  long_term_accumulator_access #(.WIN_CLKS(WIN)) long_term_accumulator_access_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .short_term_transfer_strobe(short_term_transfer_strobe), .in_baseline(in_baseline),
    .in_array(in_array), .in_point(in_point), .in_real(in_real), .in_imag(in_imag),
    .in_exp(in_exp), .front_ready(front_ready),
    .result_request_strobe(result_request_strobe), .result_addr(result_addr),
    .force_bank(force_bank), .output_word_strobe(output_word_strobe),
    .output_data(output_data), .fp_mode_strobe(fp_mode_strobe),
    .fp_mode_word(fp_mode_word), .refresh_strobe(refresh_strobe));
  filter_card_model filter_card_model_i (
    .hclk(hclk), .output_word_strobe(output_word_strobe), .output_data(output_data),
    .result_request_strobe(result_request_strobe), .result_addr(result_addr),
    .force_bank(force_bank), .real_word(real_word), .imag_word(imag_word),
    .n_words(n_words));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  // single AHB-Lite word transfer, read data taken at the closing edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic tbl(input logic [1:0] t, input logic [14:0] i, input logic [31:0] d);
    bus(1'b1, OFS_TBL_ADDR, {15'h0000, t, i});
    bus(1'b1, OFS_TBL_DATA, d);
  endtask
  // cpu storage access; polled since window timing depends on traffic
  task automatic mem(input logic w, input logic [19:0] a, input logic [31:0] hi, lo);
    int k;
    bus(1'b1, OFS_MEM_ADDR, {12'h000, a});
    bus(1'b1, OFS_MEM_HI, hi);
    bus(1'b1, OFS_MEM_LO, lo);
    bus(1'b1, OFS_MEM_CMD, {30'h0000_0000, w, 1'b1});
    for (k = 0; k < 100; k++) begin
      bus(1'b0, OFS_MEM_CMD, 32'h0000_0000);
      if (rd[0] === 1'b0) break;
    end
    check("cpu access done", 32'h0000_0000, {31'h0000_0000, rd[0]});
  endtask
  // one short-term result; busy_seen tells whether it was taken
  task automatic push(input logic [7:0] b, p, input logic [14:0] re, im);
    int k;
    in_baseline <= b;
    in_point <= p;
    in_real <= re;
    in_imag <= im;
    short_term_transfer_strobe <= 1'b1;
    @(posedge hclk);
    short_term_transfer_strobe <= 1'b0;
    @(posedge hclk);
    busy_seen = (front_ready !== 1'b1);
    for (k = 0; k < 50 && front_ready !== 1'b1; k++) @(posedge hclk);
  endtask
  task automatic rq(input logic [19:0] a, input logic fb);
    int k;
    int n;
    n = n_words;
    filter_card_model_i.request(a, fb);
    for (k = 0; k < 40 * WIN && n_words < n + 2; k++) @(posedge hclk);
    check("word count", 32'(n + 2), 32'(n_words));
  endtask

  task automatic test_regs;
    int k;
    bus(1'b0, OFS_ACCUM_CLEAR, 32'h0000_0000);
    check("accum_clear reset", 32'h0000_0000, rd);
    bus(1'b1, OFS_ACCUM_CLEAR, 32'hFFFF_FFFF);
    bus(1'b0, OFS_ACCUM_CLEAR, 32'h0000_0000);
    check("accum_clear width", 32'h0000_00FF, rd);
    bus(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped read", 32'h0000_0000, rd);
    check("hresp okay", 32'h0000_0000, {31'h0000_0000, hresp});
    bus(1'b1, OFS_MODE_WORD, 32'h5A5A_1234);
    for (k = 0; k < 100 && fp_mode_strobe !== 1'b1; k++) @(posedge hclk);
    check("mode word", 32'h5A5A_1234, fp_mode_word);
    $display("test regs done");
  endtask
  // clear, plain add, then an inhibited clear folding point 6 onto 5
  task automatic test_accum;
    tbl(TBL_MAP, 15'h0001, 32'h0000_0000);
    tbl(TBL_MAP, 15'h00D2, 32'h0000_0008);
    tbl(TBL_FE_XLAT, 15'h0005, 32'h0000_0005);
    tbl(TBL_FE_XLAT, 15'h0006, 32'h0000_0805);
    tbl(TBL_BE_XLAT, 15'h0007, 32'h0000_0005);
    tbl(TBL_BE_XLAT, 15'h4001, 32'h0000_0003);
    bus(1'b1, OFS_ACC_BANK, 32'h0000_0000);
    bus(1'b1, OFS_ACCUM_CLEAR, 32'h0000_0001);
    push(8'h01, 8'h05, 15'h0003, 15'h0001);
    bus(1'b1, OFS_ACCUM_CLEAR, 32'h0000_0000);
    push(8'h01, 8'h05, 15'h0003, 15'h0001);
    bus(1'b1, OFS_ACCUM_CLEAR, 32'h0000_0001);
    push(8'h01, 8'h06, 15'h0003, 15'h0003);
    push(TAPE_BASELINE, 8'hD2, 15'h0001, 15'h0001);
    check("tape point 210 dropped", 32'h0000_0000, {31'h0000_0000, busy_seen});
    mem(1'b0, 20'h0_0805, 32'h0000_0000, 32'h0000_0000);
    bus(1'b0, OFS_MEM_HI, 32'h0000_0000);
    check("stored real", 32'h4110_0000, rd);
    bus(1'b0, OFS_MEM_LO, 32'h0000_0000);
    check("stored imag", 32'h40A0_0000, rd);
    $display("test accum done");
  endtask
  // forced and automatic bank, then a tape validity
  task automatic test_backend;
    int k;
    int cnt;
    mem(1'b1, 20'h8_0805, 32'h1111_1111, 32'h2222_2222);
    rq(20'h0_0807, 1'b1);
    check("real word", 32'h4110_0000, real_word);
    check("imag word", 32'h40A0_0000, imag_word);
    rq(20'h0_0807, 1'b0);
    check("auto bank real", 32'h1111_1111, real_word);
    check("auto bank imag", 32'h2222_2222, imag_word);
    mem(1'b1, 20'h6_9003, 32'h0000_1234, 32'h0000_5678);
    rq(20'h6_9001, 1'b1);
    check("validity real", 32'h0000_1234, real_word);
    check("validity imag", 32'h0000_1234, imag_word);
    cnt = 0;
    for (k = 0; k < 8 * WIN; k++) begin
      @(posedge hclk);
      if (refresh_strobe === 1'b1) cnt++;
    end
    check("refresh per fft cycle", 32'h1, 32'(cnt > 0));
    $display("test backend done");
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog, well above the few hundred cycles the tests take
  initial begin
    repeat (30000) @(posedge hclk);
    $display("ERROR watchdog expected finish seen hang");
    n_fail++;
    end_of_test();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {short_term_transfer_strobe, in_baseline, in_point, in_real, in_imag} = '0;
    hsize = 3'h2;
    in_array = 3'h0;
    in_exp = 6'h00;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_accum();
    test_backend();
    end_of_test();
  end
endmodule
